// *** inc/sgc_consts.vh ***
// Register offsets, field positions, reset values and timing counts for the general config bank
`ifndef SGC_CONSTS_VH
`define SGC_CONSTS_VH
`define SGC_ADDR_GENCFG 8'h03
`define SGC_ADDR_GENCFG2 8'h04
`define SGC_ADDR_MSTCFG 8'h05
`define SGC_ADDR_PORTSEL 8'h1E
`define SGC_RST_GENCFG 8'h92
`define SGC_RST_GENCFG2 8'h00
`define SGC_RST_MSTCFG 8'h00
`define SGC_RST_PORTSEL 8'h00
`define SGC_MASK_GENCFG 8'hFA
`define SGC_MASK_GENCFG2 8'h33
`define SGC_MASK_MSTCFG 8'h1F
`define SGC_BIT_CRC_EN 7
`define SGC_BIT_PD_DIS 6
`define SGC_BIT_AUTO_ACK 5
`define SGC_BIT_FILTER 4
`define SGC_BIT_PASS_THRU 3
`define SGC_BIT_PCLK_AUTO 1
`define SGC_BIT_CRC_CLR 5
`define SGC_BIT_GATE 4
`define SGC_BIT_CRC_OV 1
`define SGC_BIT_CRC_OV_VAL 0
`define SGC_BIT_DLY_LO 3
`define SGC_BIT_PORT_SEL 0
`define SGC_PERPORT_GENCFG 8'h28
`define SGC_PERPORT_GENCFG2 8'h03
`define SGC_SDA_BASE_NS 200
`define SGC_SDA_STEP_NS 40
`define SGC_CLK_PERIOD_NS 5
`define SGC_SDA_BASE_CYC (`SGC_SDA_BASE_NS / `SGC_CLK_PERIOD_NS)
`define SGC_SDA_STEP_CYC (`SGC_SDA_STEP_NS / `SGC_CLK_PERIOD_NS)
`endif

// *** test/sgc_general_config_properties.sv ***
// Concurrent checks on the general config bank ports
`timescale 1ns/1ps
module sgc_props (
   input wire i_ref_clk,
   input wire i_resetn,
   input wire i_wr_en,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire o_ack_immediate,
   input wire i_remote_wr_req,
   input wire i_remote_wr_port,
   input wire i_remote_ack,
   input wire [1:0] o_auto_ack,
   input wire [1:0] o_pass_through,
   input wire o_pclk_auto_en,
   input wire o_crc_counter_clr,
   input wire i_sda_launch,
   input wire i_sda_bit,
   input wire o_sda_oe
);
   reg psel_reg;
   reg [1:0] code_reg;
   wire w3 = i_wr_en && i_addr == 8'h03;
   wire w4 = i_wr_en && i_addr == 8'h04;
   // Shadow copies so steering and delay checks know the live selection
   always @(posedge i_ref_clk or negedge i_resetn)
      if (!i_resetn)
      begin
         psel_reg <= 1'b0;
         code_reg <= 2'h0;
      end
      else
      begin
         psel_reg <= (i_wr_en && i_addr == 8'h1E) ? i_wdata[0] : psel_reg;
         code_reg <= (i_wr_en && i_addr == 8'h05) ? i_wdata[4:3] : code_reg;
      end
   default clocking dc @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   ack_now_a: assert property (
      o_ack_immediate == (i_remote_wr_req && (o_auto_ack[i_remote_wr_port] || i_remote_ack)))
      else $error("immediate ack wrong");
   reset_state_a: assert property ($rose(i_resetn) |-> o_pclk_auto_en && !o_auto_ack)
      else $error("reset state wrong");
   pclk_write_a: assert property (w3 |=> o_pclk_auto_en == $past(i_wdata[1]))
      else $error("auto switch bit not written");
   clr_write_a: assert property (w4 |=> o_crc_counter_clr == $past(i_wdata[5]))
      else $error("counter clear not written");
   clr_hold_a: assert property (!w4 |=> $stable(o_crc_counter_clr))
      else $error("counter clear changed alone");
   port0_steer_a: assert property (
      w3 && !psel_reg |=> o_auto_ack[0] == $past(i_wdata[5]) && $stable(o_auto_ack[1]))
      else $error("port0 write misrouted");
   port1_steer_a: assert property (
      w3 && psel_reg |=> o_pass_through[1] == $past(i_wdata[3]) && $stable(o_pass_through[0]))
      else $error("port1 write misrouted");
   sda_hold_a: assert property (i_sda_launch |=> $stable(o_sda_oe) [*8])
      else $error("sda moved early");
   sda_base_a: assert property (
      i_sda_launch && code_reg == 2'h0 |-> ##41 o_sda_oe == !$past(i_sda_bit, 41))
      else $error("sda base delay wrong");
   sda_max_a: assert property (
      i_sda_launch && code_reg == 2'h3 |-> ##65 o_sda_oe == !$past(i_sda_bit, 65))
      else $error("sda longest delay wrong");
endmodule // sgc_props
bind sgc_general_config sgc_props props_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
   .i_wr_en(i_wr_en), .i_addr(i_addr), .i_wdata(i_wdata), .o_ack_immediate(o_ack_immediate),
   .i_remote_wr_req(i_remote_wr_req), .i_remote_wr_port(i_remote_wr_port),
   .i_remote_ack(i_remote_ack), .o_auto_ack(o_auto_ack), .o_pass_through(o_pass_through),
   .o_pclk_auto_en(o_pclk_auto_en), .o_crc_counter_clr(o_crc_counter_clr),
   .i_sda_launch(i_sda_launch), .i_sda_bit(i_sda_bit), .o_sda_oe(o_sda_oe));

// *** test/sgc_host_model.sv ***
// Control bus host issuing remote writes, with a remote that acks late
`timescale 1ns/1ps
module sgc_host_model (
   input wire i_ref_clk,
   input wire i_resetn,
   input wire i_go,
   input wire i_port,
   input wire i_ack_immediate,
   output reg o_req,
   output reg o_port,
   output reg o_remote_ack,
   output reg [3:0] o_waited
);
   // Request is held until the bridge acks, so the wait count shows who answered
   always @(posedge i_ref_clk or negedge i_resetn)
      if (!i_resetn)
         {o_req, o_port, o_remote_ack, o_waited} <= 7'h00;
      else if (o_req && i_ack_immediate)
         {o_req, o_remote_ack} <= 2'h0;
      else if (o_req)
      begin
         o_waited <= o_waited + 4'h1;
         o_remote_ack <= o_waited >= 4'h5;
      end
      else if (i_go)
         {o_req, o_port, o_waited} <= {1'b1, i_port, 4'h0};
endmodule // sgc_host_model

// *** test/testbench.sv ***
// Register, video, ack and SDA timing tests for the general config bank
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   reg clk = 0, rstn = 0, wr = 0, go = 0, gp = 0, lau = 0, sb = 0, hs = 0, de = 0, clr = 0;
   reg [7:0] addr = 0, wd = 0;
   reg [1:0] caps = 0, seen = 0;
   wire [7:0] rdata;
   wire ack, req, rp, rack, ode, ohs, ovs, oe, pauto, cclr, cke, pdd, sout;
   wire [23:0] orgb;
   wire [1:0] enh, aack, pthr;
   wire [3:0] waited;
   integer n_fail = 0, checks_done = 0, cyc = 0, n, c;
   initial forever #2.5 clk = ~clk;
   sgc_general_config dut_u (.i_ref_clk(clk), .i_resetn(rstn), .i_wr_en(wr), .i_rd_en(1'b1),
      .i_addr(addr), .i_wdata(wd), .o_rdata(rdata), .o_ack_immediate(ack),
      .i_remote_wr_req(req), .i_remote_wr_port(rp), .i_remote_ack(rack), .i_pclk_en(1'b1),
      .i_de(de), .i_hs(hs), .i_vs(hs), .i_rgb(24'hABCDEF), .o_de(ode), .o_hs(ohs),
      .o_vs(ovs), .o_rgb(orgb), .i_remote_caps(caps), .o_enhanced_crc_en(enh),
      .o_auto_ack(aack), .o_pass_through(pthr), .o_crc_checker_en(cke),
      .o_io_pulldown_dis(pdd), .o_pclk_auto_en(pauto), .o_crc_counter_clr(cclr),
      .i_sda_launch(lau), .i_sda_bit(sb), .o_sda_out(sout), .o_sda_oe(oe));
   sgc_host_model host_u (.i_ref_clk(clk), .i_resetn(rstn), .i_go(go), .i_port(gp),
      .i_ack_immediate(ack), .o_req(req), .o_port(rp), .o_remote_ack(rack), .o_waited(waited));
   always @(negedge clk) seen <= clr ? 2'h0 : (seen | {ohs, ovs});
   always @(posedge clk)
   begin
      cyc++;
      // Whole run needs a few hundred cycles
      if (cyc == 20000)
      begin
         n_fail++;
         finish_test;
      end
   end
   task finish_test;
      if (n_fail == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task wrr(input [7:0] a, input [7:0] d);
      @(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
      @(posedge clk) wr <= 1'b0;
      // Let the write settle before the caller looks at outputs
      @(negedge clk);
   endtask
   task rdc(input [7:0] a, input [7:0] e);
      @(posedge clk) addr <= a;
      @(negedge clk) `CHK(rdata, e)
   endtask
   task hostw(input p, input [3:0] e);
      @(posedge clk) {go, gp} <= {1'b1, p};
      @(posedge clk) go <= 1'b0;
      repeat (12) @(posedge clk);
      `CHK(waited, e)
   endtask
   task pulse(input [3:0] len, input [1:0] e);
      @(posedge clk) {hs, clr} <= 2'h3;
      repeat (len) @(posedge clk) clr <= 1'b0;
      hs <= 1'b0;
      repeat (10) @(posedge clk);
      `CHK(seen, e)
   endtask
   task sda(input [1:0] k);
      wrr(8'h05, {3'h0, k, 3'h0});
      @(posedge clk) {lau, sb} <= {1'b1, k[0]};
      @(posedge clk) lau <= 1'b0;
      n = 0;
      @(negedge clk);
      while (oe !== ~k[0] && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      `CHK(n, (200 + 40 * k) / 5)
      `CHK(sout, 1'b0)
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      rdc(8'h03, 8'h92);
      `CHK({cke, pdd}, 2'h2)
      rdc(8'h04, 8'h00);
      rdc(8'h05, 8'h00);
      pulse(1, 2'h0);
      pulse(4, 2'h3);
      pulse(2, 2'h3);
      wrr(8'h40, 8'hFF);
      rdc(8'h40, 8'h00);
      wrr(8'h04, 8'hFF);
      rdc(8'h04, 8'h33);
      repeat (6) @(posedge clk);
      `CHK(cclr, 1'b1)
      wrr(8'h05, 8'hFF);
      rdc(8'h05, 8'h1F);
      wrr(8'h03, 8'h00);
      `CHK(pauto, 1'b0)
      pulse(1, 2'h3);
      wrr(8'h03, 8'h20);
      wrr(8'h1E, 8'h01);
      wrr(8'h03, 8'h08);
      rdc(8'h03, 8'h08);
      `CHK({aack, pthr}, 4'h6)
      wrr(8'h1E, 8'h00);
      rdc(8'h03, 8'h20);
      hostw(1'b0, 4'h0);
      hostw(1'b1, 4'h6);
      @(posedge clk) caps <= 2'h2;
      wrr(8'h04, 8'h00);
      `CHK({cclr, enh}, 3'h2)
      wrr(8'h04, 8'h03);
      `CHK(enh, 2'h3)
      wrr(8'h1E, 8'h01);
      wrr(8'h04, 8'h02);
      `CHK(enh, 2'h1)
      wrr(8'h1E, 8'h00);
      repeat (6) @(posedge clk);
      `CHK(orgb, 24'hABCDEF)
      wrr(8'h04, 8'h10);
      repeat (6) @(posedge clk);
      `CHK(orgb, 24'h0)
      @(posedge clk) de <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK({ode, orgb}, 25'h1ABCDEF)
      for (c = 0; c < 4; c++)
         sda(c);
      finish_test;
   end
endmodule // testbench

// *** verilog/sgc_general_config.v ***
// General configuration register bank of the serializer with its steered control logic
// Notes on behaviour
// RL1: With auto-acknowledge on, remote writes are acknowledged at once, not after remote ack.
// RL2: Filter enabled at reset rejects DE, HS, VS pulses under two pixel clocks.
// RL3: Pixel clock auto-switch enable bit, set at reset; clear disables auto-switching.
// RL4: CRC counter clear bit holds counters cleared until software writes zero.
// RL5: Gating bit set masks RGB data with DE; clear passes data freely.
// RL6: Override clear uses remote capability list; set uses override value.
// RL7: Override value one enables enhanced CRC and start sequence, zero disables.
// RL8: Port-select set steers per-port field reads and writes to the second copy.
// RL9: Two-bit SDA delay adds 40 ns steps from 200 ns up to 320 ns.
`timescale 1ns/1ps
`include "sgc_consts.vh"
module sgc_general_config #(
   parameter PIX_W = 24
) (
   input wire i_ref_clk,
   input wire i_resetn,
   input wire i_wr_en,
   input wire i_rd_en,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   output wire o_ack_immediate,
   input wire i_remote_wr_req,
   input wire i_remote_wr_port,
   input wire i_remote_ack,
   input wire i_pclk_en,
   input wire i_de,
   input wire i_hs,
   input wire i_vs,
   input wire [PIX_W-1:0] i_rgb,
   output reg o_de,
   output reg o_hs,
   output reg o_vs,
   output reg [PIX_W-1:0] o_rgb,
   input wire [1:0] i_remote_caps,
   output wire [1:0] o_enhanced_crc_en,
   output wire [1:0] o_auto_ack,
   output wire [1:0] o_pass_through,
   output wire o_crc_checker_en,
   output wire o_io_pulldown_dis,
   output wire o_pclk_auto_en,
   output wire o_crc_counter_clr,
   input wire i_sda_launch,
   input wire i_sda_bit,
   output reg o_sda_out,
   output reg o_sda_oe
);
   reg [7:0] gencfg_reg;
   reg [7:0] gencfg_p1_reg;
   reg [7:0] gencfg2_reg;
   reg [7:0] gencfg2_p1_reg;
   reg [7:0] mstcfg_reg;
   reg [7:0] portsel_reg;
   reg [7:0] sda_cnt_reg;
   reg sda_state_reg;
   reg sda_val_reg;
   wire port1;
   wire [7:0] dly_cycles;
   wire [2:0] pin_in;
   wire [2:0] ctl_sync;
   wire [2:0] ctl_out;

   localparam SDA_IDLE = 1'b0;
   localparam SDA_WAIT = 1'b1;
   localparam integer SDA_BASE_I = `SGC_SDA_BASE_CYC;
   localparam [7:0] SDA_BASE = SDA_BASE_I[7:0];

   // Masked merge: per-port bits go to the selected copy only, shared bits to both images
   function [7:0] sgc_merge;
      input [7:0] old_v;
      input [7:0] new_v;
      input [7:0] mask;
      begin
         sgc_merge = (old_v & ~mask) | (new_v & mask);
      end
   endfunction

   assign port1 = portsel_reg[`SGC_BIT_PORT_SEL];

   always @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         gencfg_reg <= `SGC_RST_GENCFG;
         gencfg_p1_reg <= `SGC_RST_GENCFG;
         gencfg2_reg <= `SGC_RST_GENCFG2;
         gencfg2_p1_reg <= `SGC_RST_GENCFG2;
         mstcfg_reg <= `SGC_RST_MSTCFG;
         portsel_reg <= `SGC_RST_PORTSEL;
      end
      else if (i_wr_en)
      begin
         case (i_addr)
            `SGC_ADDR_GENCFG:
            begin
               // Shared bits land in both images so either read view agrees
               if (port1) // RL8
               begin
                  gencfg_p1_reg <= i_wdata & `SGC_MASK_GENCFG;
                  gencfg_reg <= sgc_merge(gencfg_reg, i_wdata,
                     `SGC_MASK_GENCFG & ~`SGC_PERPORT_GENCFG);
               end
               else
               begin
                  gencfg_reg <= i_wdata & `SGC_MASK_GENCFG;
                  gencfg_p1_reg <= sgc_merge(gencfg_p1_reg, i_wdata,
                     `SGC_MASK_GENCFG & ~`SGC_PERPORT_GENCFG);
               end
            end
            `SGC_ADDR_GENCFG2:
            begin
               if (port1) // RL8
               begin
                  gencfg2_p1_reg <= i_wdata & `SGC_MASK_GENCFG2;
                  gencfg2_reg <= sgc_merge(gencfg2_reg, i_wdata,
                     `SGC_MASK_GENCFG2 & ~`SGC_PERPORT_GENCFG2);
               end
               else
               begin
                  gencfg2_reg <= i_wdata & `SGC_MASK_GENCFG2;
                  gencfg2_p1_reg <= sgc_merge(gencfg2_p1_reg, i_wdata,
                     `SGC_MASK_GENCFG2 & ~`SGC_PERPORT_GENCFG2);
               end
            end
            `SGC_ADDR_MSTCFG: mstcfg_reg <= i_wdata & `SGC_MASK_MSTCFG;
            `SGC_ADDR_PORTSEL: portsel_reg <= {7'h00, i_wdata[`SGC_BIT_PORT_SEL]};
            default: ;
         endcase
      end
   end

   always @*
   begin
      case (i_addr)
         `SGC_ADDR_GENCFG: o_rdata = port1 ? gencfg_p1_reg : gencfg_reg; // RL8
         `SGC_ADDR_GENCFG2: o_rdata = port1 ? gencfg2_p1_reg : gencfg2_reg; // RL8
         `SGC_ADDR_MSTCFG: o_rdata = mstcfg_reg;
         `SGC_ADDR_PORTSEL: o_rdata = portsel_reg;
         default: o_rdata = 8'h00;
      endcase
   end

   assign o_crc_checker_en = gencfg_reg[`SGC_BIT_CRC_EN];
   assign o_io_pulldown_dis = gencfg_reg[`SGC_BIT_PD_DIS];
   assign o_pclk_auto_en = gencfg_reg[`SGC_BIT_PCLK_AUTO]; // RL3
   assign o_crc_counter_clr = gencfg2_reg[`SGC_BIT_CRC_CLR]; // RL4
   assign o_auto_ack = {gencfg_p1_reg[`SGC_BIT_AUTO_ACK], gencfg_reg[`SGC_BIT_AUTO_ACK]};
   assign o_pass_through = {gencfg_p1_reg[`SGC_BIT_PASS_THRU],
      gencfg_reg[`SGC_BIT_PASS_THRU]};

   // Ack now when the target port auto-acks; otherwise wait for the far end
   assign o_ack_immediate = i_remote_wr_req &
      (o_auto_ack[i_remote_wr_port] | i_remote_ack); // RL1

   // Remote capability decides unless the override is set
   genvar gp;
   generate
      for (gp = 0; gp < 2; gp = gp + 1)
      begin : g_crc
         wire [7:0] cfg2 = (gp == 0) ? gencfg2_reg : gencfg2_p1_reg;
         assign o_enhanced_crc_en[gp] = cfg2[`SGC_BIT_CRC_OV] ?
            cfg2[`SGC_BIT_CRC_OV_VAL] : i_remote_caps[gp]; // RL6 RL7
      end
   endgenerate

   // Video path: pins are synchronised first, then filtered per channel
   assign pin_in = {i_vs, i_hs, i_de};

   genvar ch;
   generate
      for (ch = 0; ch < 3; ch = ch + 1)
      begin : g_filt
         reg [1:0] sync_reg;
         reg hist_reg;
         reg out_reg;
         always @(posedge i_ref_clk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               sync_reg <= 2'h0;
               hist_reg <= 1'b0;
               out_reg <= 1'b0;
            end
            else
            begin
               sync_reg <= {sync_reg[0], pin_in[ch]};
               if (i_pclk_en)
               begin
                  hist_reg <= sync_reg[1];
                  // Two equal pixel clock samples pass; a one-sample pulse never matches
                  if (!gencfg_reg[`SGC_BIT_FILTER] || hist_reg == sync_reg[1]) // RL2
                     out_reg <= sync_reg[1];
               end
            end
         end
         assign ctl_sync[ch] = sync_reg[1];
         assign ctl_out[ch] = out_reg;
      end
   endgenerate

   // Control outputs come straight from the filter flip-flops
   always @*
   begin
      o_de = ctl_out[0];
      o_hs = ctl_out[1];
      o_vs = ctl_out[2];
   end

   // RGB is taken from logic on this clock, so it is not synchronised
   always @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_rgb <= {PIX_W{1'b0}};
      else if (i_pclk_en)
      begin
         if (gencfg2_reg[`SGC_BIT_GATE] && !ctl_sync[0]) // RL5
            o_rgb <= {PIX_W{1'b0}};
         else
            o_rgb <= i_rgb;
      end
   end

   // SDA launch delayed by base plus code times step; a step is eight 5 ns cycles
   assign dly_cycles = SDA_BASE +
      {3'h0, mstcfg_reg[`SGC_BIT_DLY_LO+1:`SGC_BIT_DLY_LO], 3'h0}; // RL9

   always @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sda_state_reg <= SDA_IDLE;
         sda_cnt_reg <= 8'h00;
         sda_val_reg <= 1'b1;
         o_sda_out <= 1'b1;
         o_sda_oe <= 1'b0;
      end
      else
      begin
         case (sda_state_reg)
            SDA_IDLE:
            begin
               if (i_sda_launch)
               begin
                  sda_cnt_reg <= dly_cycles - 8'h01;
                  sda_val_reg <= i_sda_bit;
                  sda_state_reg <= SDA_WAIT;
               end
            end
            SDA_WAIT:
            begin
               if (i_sda_launch)
               begin
                  // A new launch restarts the delay; the older bit is dropped
                  sda_cnt_reg <= dly_cycles - 8'h01;
                  sda_val_reg <= i_sda_bit;
               end
               else if (sda_cnt_reg == 8'h00) // RL9
               begin
                  // Open drain: the line is only pulled low, a one releases it
                  o_sda_out <= 1'b0;
                  o_sda_oe <= ~sda_val_reg;
                  sda_state_reg <= SDA_IDLE;
               end
               else
                  sda_cnt_reg <= sda_cnt_reg - 8'h01;
            end
            default: sda_state_reg <= SDA_IDLE;
         endcase
      end
   end
endmodule // sgc_general_config
